// ===== logic/stc_top_control_regs.sv
// Purpose: top control register pair with calibration, mute, sync and pin logic
// Assumes: zero-wait APB slave, reference clock equals clk
// Notes: unmapped addresses answer pslverr and read zero
`timescale 1ns/1ps
`default_nettype none
module stc_top_control_regs
    import stc_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [DATA_W-1:0] pwdata, // apb write data
    output logic [DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic lockDetect, // lock indication
    input wire logic readbackData, // serial readback bit
    output logic muxPinOut, // multiplexed_status_pin data
    output logic muxPinOe_n, // pin enable, low drives
    output stc_ctrl_s ctrl, // analog control levels
    output logic syncPulse // one-cycle sync pulse
);
    function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
        addrHit = (a == {idx, 2'b00});
    endfunction : addrHit

    // reset release through two flops
    logic rstS1_q;
    logic rstS2_q;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstS1_q <= 1'b0;
            rstS2_q <= 1'b0;
        end
        else
        begin
            rstS1_q <= 1'b1;
            rstS2_q <= rstS1_q;
        end
    end
    assign rst_n = rstS2_q;

    // apb decode, no wait states
    logic hitMain;
    logic hitPin;
    logic access;
    logic wrMain;
    logic wrPin;
    assign hitMain = addrHit(paddr, IDX_MAIN);
    assign hitPin = addrHit(paddr, IDX_PIN);
    assign access = psel && penable;
    assign wrMain = access && pwrite && hitMain;
    assign wrPin = access && pwrite && hitPin;
    assign pready = 1'b1;
    assign pslverr = access && !(hitMain || hitPin);

    // register bank
    logic [REG_W-1:0] main_q;
    logic [REG_W-1:0] main_d;
    logic [REG_W-1:0] pin_q;
    logic [REG_W-1:0] pin_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic syncPulse_q;
    logic syncPulse_d;
    always_comb
    begin
        main_d = wrMain ? pwdata[REG_W-1:0] : main_q;
        pin_d = wrPin ? pwdata[REG_W-1:0] : pin_q;
        // soft reset keeps its own bit so the host can clear it
        if (main_d[MAIN_SRST_BIT])
        begin
            main_d = MAIN_RST | (REG_W'(1) << MAIN_SRST_BIT);
            pin_d = PIN_RST;
        end
        syncPulse_d = !main_q[MAIN_SYNC_BIT] && main_d[MAIN_SYNC_BIT];
        // read data captured in the setup phase
        prdata_d = prdata_q;
        if (psel && !penable)
        begin
            prdata_d = '0;
            if (hitMain)
                prdata_d[REG_W-1:0] = main_q;
            else if (hitPin)
                prdata_d[REG_W-1:0] = pin_q;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_q <= MAIN_RST;
            pin_q <= PIN_RST;
            prdata_q <= '0;
            syncPulse_q <= 1'b0;
        end
        else
        begin
            main_q <= main_d;
            pin_q <= pin_d;
            prdata_q <= prdata_d;
            syncPulse_q <= syncPulse_d;
        end
    end
    assign prdata = prdata_q;
    assign syncPulse = syncPulse_q;

    logic softRst;
    assign softRst = main_q[MAIN_SRST_BIT];

    // calibration clock divider, tick every 2**div cycles
    logic [DIVCNT_W-1:0] divCnt_q;
    logic [DIVCNT_W-1:0] divCnt_d;
    logic [DIVCNT_W-1:0] divLimit;
    logic tick;
    assign divLimit = DIVCNT_W'((8'h01 << pin_q[PIN_DIV_LO +: DIV_W]) - 8'h01);
    // >= so a smaller divider never waits for a wrap
    assign tick = (divCnt_q >= divLimit);
    always_comb
    begin
        divCnt_d = (tick || softRst) ? '0 : divCnt_q + DIVCNT_W'(1);
    end

    // calibration state machine
    stc_cal_e calState_q;
    stc_cal_e calState_d;
    logic [CALCNT_W-1:0] calCnt_q;
    logic [CALCNT_W-1:0] calCnt_d;
    always_comb
    begin
        calState_d = calState_q;
        calCnt_d = calCnt_q;
        // abort wins over a start; the release write may start one
        if (main_d[MAIN_SRST_BIT] || main_d[MAIN_PD_BIT])
        begin
            calState_d = CAL_IDLE;
            calCnt_d = '0;
        end
        else if (wrMain && pwdata[MAIN_CAL_BIT])
        begin
            calState_d = CAL_RUN;
            calCnt_d = '0;
        end
        else
        begin
            unique case (calState_q)
                CAL_IDLE:
                    calCnt_d = '0;
                CAL_RUN:
                    if (tick)
                    begin
                        if (calCnt_q == CAL_TICKS - CALCNT_W'(1))
                            calState_d = CAL_IDLE;
                        calCnt_d = calCnt_q + CALCNT_W'(1);
                    end
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_q <= '0;
            calState_q <= CAL_IDLE;
            calCnt_q <= '0;
        end
        else
        begin
            divCnt_q <= divCnt_d;
            calState_q <= calState_d;
            calCnt_q <= calCnt_d;
        end
    end

    // analog controls and status pin
    stc_ctrl_s ctrl_q;
    stc_ctrl_s ctrl_d;
    logic muxPinOut_q;
    logic muxPinOut_d;
    logic muxPinOe_n_q;
    logic muxPinOe_n_d;
    // ctrl taken from next values so it moves at the write edge
    logic calBusyNext;
    always_comb
    begin
        calBusyNext = (calState_d == CAL_RUN);
        ctrl_d.sleep = main_d[MAIN_PD_BIT];
        ctrl_d.syncMode = main_d[MAIN_SYNC_BIT];
        ctrl_d.muteA = main_d[MAIN_MUTE_BIT] && calBusyNext;
        ctrl_d.muteB = main_d[MAIN_MUTE_BIT] && calBusyNext;
        ctrl_d.calBusy = calBusyNext;
        ctrl_d.pfdAdjust = main_d[MAIN_ADJ_LO +: 2];
        muxPinOut_d = main_q[MAIN_SEL_BIT] ? lockDetect : readbackData;
        muxPinOe_n_d = !pin_q[PIN_DRV_BIT];
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= '0;
            muxPinOut_q <= 1'b0;
            muxPinOe_n_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            muxPinOut_q <= muxPinOut_d;
            muxPinOe_n_q <= muxPinOe_n_d;
        end
    end
    assign ctrl = ctrl_q;
    assign muxPinOut = muxPinOut_q;
    assign muxPinOe_n = muxPinOe_n_q;
endmodule : stc_top_control_regs
`default_nettype wire

// ===== logic/stc_pkg.sv
// Purpose: constants and types of the synthesizer top control register pair
// Assumes: APB slave, 32-bit data, registers at four times their index
// Notes: shared by the register bank and the bench
//
// Behaviour
// - phase-sync bit 14 set puts the channel divider in the feedback loop.
// - a 0-to-1 change of phase-sync bit 14 emits one sync pulse.
// - mute bit 9 mutes both radio outputs while calibration runs.
// - a write to main_control with bit 3 set starts a calibration unless bit 0 or bit 1 is also set.
// - bit 2 selects readback data (0) or lock detect (1) on the pin.
// - while soft reset bit 1 is 1, registers and state machines stay reset.
// - power-down bit 0 puts device asleep when 1.
// - main_control resets to 0x200c.
// - second register bit 3 tri-states the pin when 0, drives when 1.
// - bits 2-0 divide reference by two to that power for calibration clock.
package stc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_MAIN = 10'h000;
    localparam logic [IDX_W-1:0] IDX_PIN = 10'h001;
    localparam logic [REG_W-1:0] MAIN_RST = 16'h200c;
    localparam logic [REG_W-1:0] PIN_RST = 16'h080c;
    localparam int MAIN_PD_BIT = 0;
    localparam int MAIN_SRST_BIT = 1;
    localparam int MAIN_SEL_BIT = 2;
    localparam int MAIN_CAL_BIT = 3;
    localparam int MAIN_ADJ_LO = 7;
    localparam int MAIN_MUTE_BIT = 9;
    localparam int MAIN_SYNC_BIT = 14;
    localparam int PIN_DRV_BIT = 3;
    localparam int PIN_DIV_LO = 0;
    localparam int DIV_W = 3;
    localparam int DIVCNT_W = 7;
    localparam int CALCNT_W = 8;
    // calibration length in state-machine ticks, arbitrary model value
    localparam logic [CALCNT_W-1:0] CAL_TICKS = 8'h10;

    typedef enum logic {CAL_IDLE, CAL_RUN} stc_cal_e;

    typedef struct packed {
        logic sleep;
        logic syncMode;
        logic muteA;
        logic muteB;
        logic calBusy;
        logic [1:0] pfdAdjust;
    } stc_ctrl_s;
endpackage : stc_pkg

// ===== bench/stc_top_control_regs_assertions.sv
// Purpose: port checks of the control register pair
// Assumes: bound to stc_top_control_regs
// Notes: ctrl may follow a write by one or two edges
`timescale 1ns/1ps
`default_nettype none
module stc_top_control_regs_assertions
    import stc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic syncPulse, // sync pulse
    input wire logic [ADDR_W-1:0] paddr, // address
    input wire logic [DATA_W-1:0] pwdata, // write data
    input wire logic [DATA_W-1:0] prdata, // read data
    input wire stc_ctrl_s ctrl // control levels
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic acc, wrMain;
    assign acc = psel && penable;
    assign wrMain = acc && pwrite && paddr == 12'h000 && !pwdata[1];
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
        else $error("pslverr wrong");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000) else $error("prdata upper");
    a_sync_pulse: assert property ($rose(ctrl.syncMode) |-> syncPulse) else $error("no sync pulse");
    a_pulse_single: assert property (syncPulse |=> !syncPulse) else $error("pulse too long");
    a_pulse_mode: assert property (syncPulse |-> ctrl.syncMode) else $error("pulse without sync");
    a_mute_cal: assert property (ctrl.muteA == ctrl.muteB && (!ctrl.muteA || ctrl.calBusy)) else $error("mute");
    a_cal_start: assert property (wrMain && pwdata[3] && !pwdata[0] && !ctrl.sleep |-> ##[1:2] ctrl.calBusy)
        else $error("no calibration");
    a_mute_on: assert property (wrMain && pwdata[9] && pwdata[3] && !pwdata[0] && !ctrl.sleep |-> ##[1:2] ctrl.muteA)
        else $error("no mute");
    a_sleep_follow: assert property (wrMain && pwdata[0] |-> ##[1:2] ctrl.sleep) else $error("no sleep");
    cover property (syncPulse);
    cover property (ctrl.muteA);
    cover property (acc && pslverr);
endmodule : stc_top_control_regs_assertions
`default_nettype wire

// ===== bench/stc_top_control_regs_tb.sv
// Purpose: self-checking bench of the control register pair
// Assumes: zero-wait apb slave
// Notes: calibration checked with short dividers
`timescale 1ns/1ps
`default_nettype none
module stc_top_control_regs_tb import stc_pkg::*;;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, lockDetect, readbackData;
    logic muxPinOut, muxPinOe_n, syncPulse, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    stc_ctrl_s ctrl;
    int n_errors = 0, n_tests = 0, cyc = 0, pulses = 0, p0, k;
    stc_top_control_regs dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .lockDetect, .readbackData, .muxPinOut, .muxPinOe_n, .ctrl, .syncPulse);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        pulses <= pulses + (syncPulse === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic t_reset(input bit midRun);
        if (midRun)
            arst_n <= 1'b0;
        repeat (midRun ? 3 : 10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, 12'h000, 0);
        chk("main", 32'h200c, rd);
        chk("sleep", 0, ctrl.sleep);
        apb(0, 12'h004, 0);
        chk("pin", 32'h080c, rd);
        chk("oe_n", 0, muxPinOe_n);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_pin();
        lockDetect <= 1'b1;
        apb(1, 12'h000, 32'hffff2014);
        apb(0, 12'h000, 0);
        chk("main", 32'h2014, rd);
        chk("pin", 1, muxPinOut);
        apb(1, 12'h000, 32'h2010);
        repeat (2) @(posedge clk);
        chk("pin", 0, muxPinOut);
        readbackData <= 1'b1;
        apb(1, 12'h004, 32'h0804);
        apb(0, 12'h004, 0);
        chk("pinreg", 32'h0804, rd);
        chk("oe_n", 1, muxPinOe_n);
        chk("pin", 1, muxPinOut);
        apb(1, 12'h004, 32'h080c);
        repeat (2) @(posedge clk);
        chk("oe_n", 0, muxPinOe_n);
        $display("t_pin done");
    endtask : t_pin
    task automatic t_cal();
        for (k = 0; k < 2; k++)
        begin
            apb(1, 12'h004, 32'h0808 | k);
            apb(1, 12'h000, k ? 32'h2018 : 32'h2218);
            @(posedge clk);
            chk("busy", 1, ctrl.calBusy);
            chk("mute", !k, ctrl.muteA);
            repeat (14 << k) @(posedge clk);
            chk("busy", 1, ctrl.calBusy);
            repeat (4 << k) @(posedge clk);
            chk("busy", 0, ctrl.calBusy);
            chk("mute", 0, ctrl.muteB);
        end
        apb(1, 12'h000, 32'h2010);
        repeat (3) @(posedge clk);
        chk("busy", 0, ctrl.calBusy);
        $display("t_cal done");
    endtask : t_cal
    task automatic t_srst();
        apb(1, 12'h000, 32'h2018);
        apb(1, 12'h000, 32'h201a);
        apb(1, 12'h004, 32'h0800);
        apb(0, 12'h004, 0);
        chk("pin", 32'h080c, rd);
        apb(0, 12'h000, 0);
        chk("main", 32'h200e, rd);
        chk("busy", 0, ctrl.calBusy);
        apb(1, 12'h000, 32'h2010);
        apb(0, 12'h000, 0);
        chk("main", 32'h2010, rd);
        $display("t_srst done");
    endtask : t_srst
    task automatic t_modes();
        for (k = 0; k < 2; k++)
        begin
            p0 = pulses;
            apb(1, 12'h000, 32'h6010);
            repeat (3) @(posedge clk);
            chk("pulses", !k, pulses - p0);
            chk("sync", 1, ctrl.syncMode);
        end
        apb(1, 12'h000, 32'h2191);
        apb(0, 12'h008, 0);
        chk("err", 1, er);
        chk("bad", 0, rd);
        chk("sleep", 1, ctrl.sleep);
        chk("sync", 0, ctrl.syncMode);
        chk("adj", 3, ctrl.pfdAdjust);
        apb(1, 12'h008, 32'h0);
        chk("err", 1, er);
        apb(0, 12'h000, 0);
        chk("main", 32'h2191, rd);
        $display("t_modes done");
    endtask : t_modes
    initial
    begin
        {arst_n, psel, penable, pwrite, lockDetect, readbackData} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        t_reset(1'b0);
        t_pin();
        t_cal();
        t_srst();
        t_modes();
        t_reset(1'b1);
        give_verdict();
    end
endmodule : stc_top_control_regs_tb
bind stc_top_control_regs stc_top_control_regs_assertions u_chk (.clk, .arst_n, .psel, .penable, .pwrite,
    .pready, .pslverr, .syncPulse, .paddr, .pwdata, .prdata, .ctrl);
`default_nettype wire
